// >>> hdl/jtd_pkg.sv
// shared constants and types of the test access port decoder
package jtd_pkg;
   // register widths and user register count
   localparam int IR_WIDTH = 5;
   localparam int ID_WIDTH = 32;
   localparam int BSR_WIDTH = 10;
   localparam int USER_COUNT = 8;
   // instruction codes
   localparam logic [4:0] INSTR_EXTEST = 5'h01;
   localparam logic [4:0] INSTR_HIGHZ = 5'h02;
   localparam logic [4:0] INSTR_INTEST = 5'h03;
   localparam logic [4:0] INSTR_CLAMP = 5'h04;
   localparam logic [4:0] INSTR_SAMPLE = 5'h05;
   localparam logic [4:0] IDENTIFY_INSTR = 5'h0E;
   localparam logic [4:0] BIAS_PROGRAM_INSTR = 5'h0F;
   localparam logic [4:0] LINE_PATTERN_FIRST_INSTR = 5'h10;
   localparam logic [4:0] DISCRIMINATOR_MASK_INSTR = 5'h11;
   localparam logic [4:0] SEQUENCER_INSTR = 5'h12;
   localparam logic [4:0] CONTROL_INSTR = 5'h13;
   localparam logic [4:0] LINE_PATTERN_SECOND_INSTR = 5'h14;
   localparam logic [4:0] RESERVED_CODE_A = 5'h15;
   localparam logic [4:0] RESERVED_CODE_H = 5'h1C;
   localparam logic [4:0] READOUT_CONFIG_SECOND = 5'h1D;
   localparam logic [4:0] READOUT_CONFIG_FIRST = 5'h1E;
   localparam logic [4:0] INSTR_BYPASS = 5'h1F;
   // reset and capture values
   localparam logic [4:0] IR_RESET_VALUE = IDENTIFY_INSTR;
   localparam logic [1:0] IR_CAPTURE_MARK = 2'h1;
   localparam int IR_MARK_WIDTH = 2;
   localparam logic [31:0] ID_DEFAULT = 32'h0ACE0001; // value is arbitrary
   // user register index, bit of the select vectors
   localparam int U_BIAS = 0;
   localparam int U_LINE_FIRST = 1;
   localparam int U_DISC = 2;
   localparam int U_SEQ = 3;
   localparam int U_CTRL = 4;
   localparam int U_LINE_SECOND = 5;
   localparam int U_RO_SECOND = 6;
   localparam int U_RO_FIRST = 7;
   // power-on hold time
   localparam int CLK_MHZ = 25;
   localparam int POR_TIME_NS = 1000;
   localparam int POR_CYCLES = (POR_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int POR_CNT_WIDTH = 8;
   // port controller states
   typedef enum logic [3:0] {
      TAP_RESET = 4'hF, TAP_IDLE = 4'hC,
      TAP_SEL_DR = 4'h7, TAP_CAP_DR = 4'h6, TAP_SHIFT_DR = 4'h2,
      TAP_EXIT1_DR = 4'h1, TAP_PAUSE_DR = 4'h3, TAP_EXIT2_DR = 4'h0,
      TAP_UPD_DR = 4'h5,
      TAP_SEL_IR = 4'h4, TAP_CAP_IR = 4'hE, TAP_SHIFT_IR = 4'hA,
      TAP_EXIT1_IR = 4'h9, TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h8,
      TAP_UPD_IR = 4'hD
   } jtd_tap_state_type;
   // scan path between serial in and serial out
   typedef enum logic [1:0] {
      PATH_BYPASS = 2'h0, PATH_BSR = 2'h1, PATH_IDENT = 2'h2, PATH_USER = 2'h3
   } jtd_path_type;
endpackage

// >>> hdl/jtd_tap_if.sv
// controller state carried from the state machine to the decoder
`timescale 1ns/1ps
interface jtd_tap_if;
   jtd_pkg::jtd_tap_state_type state;
   jtd_pkg::jtd_tap_state_type next_state;
   modport fsm (output state, output next_state);
   modport user (input state, input next_state);
endinterface

// >>> hdl/jtd_tap_fsm.sv
// sixteen-state test access port controller
`timescale 1ns/1ps
module jtd_tap_fsm
(
   // link clock and reset
   input wire logic tck,
   input wire logic rst_n,
   // power-on hold and mode select
   input wire logic hold,
   input wire logic tms,
   // state to the decoder
   jtd_tap_if.fsm tap
);
   jtd_pkg::jtd_tap_state_type state;
   jtd_pkg::jtd_tap_state_type next_state;

   // next state from mode select
   always_comb
   begin
      next_state = state;
      case (state)
         jtd_pkg::TAP_RESET: next_state = tms ? jtd_pkg::TAP_RESET : jtd_pkg::TAP_IDLE;
         jtd_pkg::TAP_IDLE: next_state = tms ? jtd_pkg::TAP_SEL_DR : jtd_pkg::TAP_IDLE;
         jtd_pkg::TAP_SEL_DR: next_state = tms ? jtd_pkg::TAP_SEL_IR : jtd_pkg::TAP_CAP_DR;
         jtd_pkg::TAP_CAP_DR: next_state = tms ? jtd_pkg::TAP_EXIT1_DR : jtd_pkg::TAP_SHIFT_DR;
         jtd_pkg::TAP_SHIFT_DR: next_state = tms ? jtd_pkg::TAP_EXIT1_DR : jtd_pkg::TAP_SHIFT_DR;
         jtd_pkg::TAP_EXIT1_DR: next_state = tms ? jtd_pkg::TAP_UPD_DR : jtd_pkg::TAP_PAUSE_DR;
         jtd_pkg::TAP_PAUSE_DR: next_state = tms ? jtd_pkg::TAP_EXIT2_DR : jtd_pkg::TAP_PAUSE_DR;
         jtd_pkg::TAP_EXIT2_DR: next_state = tms ? jtd_pkg::TAP_UPD_DR : jtd_pkg::TAP_SHIFT_DR;
         jtd_pkg::TAP_UPD_DR: next_state = tms ? jtd_pkg::TAP_SEL_DR : jtd_pkg::TAP_IDLE;
         jtd_pkg::TAP_SEL_IR: next_state = tms ? jtd_pkg::TAP_RESET : jtd_pkg::TAP_CAP_IR;
         jtd_pkg::TAP_CAP_IR: next_state = tms ? jtd_pkg::TAP_EXIT1_IR : jtd_pkg::TAP_SHIFT_IR;
         jtd_pkg::TAP_SHIFT_IR: next_state = tms ? jtd_pkg::TAP_EXIT1_IR : jtd_pkg::TAP_SHIFT_IR;
         jtd_pkg::TAP_EXIT1_IR: next_state = tms ? jtd_pkg::TAP_UPD_IR : jtd_pkg::TAP_PAUSE_IR;
         jtd_pkg::TAP_PAUSE_IR: next_state = tms ? jtd_pkg::TAP_EXIT2_IR : jtd_pkg::TAP_PAUSE_IR;
         jtd_pkg::TAP_EXIT2_IR: next_state = tms ? jtd_pkg::TAP_UPD_IR : jtd_pkg::TAP_SHIFT_IR;
         jtd_pkg::TAP_UPD_IR: next_state = tms ? jtd_pkg::TAP_SEL_DR : jtd_pkg::TAP_IDLE;
         default: next_state = jtd_pkg::TAP_RESET;
      endcase
      if (hold)
      begin
         next_state = jtd_pkg::TAP_RESET;
      end
   end

   // state register, starts in test-logic-reset
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= jtd_pkg::TAP_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign tap.state = state;
   assign tap.next_state = next_state;
endmodule

// >>> hdl/jtd_decoder.sv
// test access port with instruction decoder and data path select
`timescale 1ns/1ps
module jtd_decoder
#(
   parameter logic [31:0] ID_VALUE = jtd_pkg::ID_DEFAULT, // value is arbitrary
   parameter int USER_COUNT = jtd_pkg::USER_COUNT,
   parameter int BSR_WIDTH = jtd_pkg::BSR_WIDTH
)
(
   // system clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // serial test link
   input wire logic TCK_IN,
   input wire logic TMS_IN,
   input wire logic TDI_IN,
   output logic TDO_OUT,
   output logic TDO_OE_OUT,
   // user data registers
   input wire logic [USER_COUNT-1:0] USER_TDO_IN,
   output logic [USER_COUNT-1:0] USER_SELECT_OUT,
   output logic [USER_COUNT-1:0] USER_CAPTURE_OUT,
   output logic [USER_COUNT-1:0] USER_SHIFT_OUT,
   output logic [USER_COUNT-1:0] USER_UPDATE_OUT,
   // boundary pads
   input wire logic [BSR_WIDTH-1:0] BSR_PADS_IN,
   output logic [BSR_WIDTH-1:0] BSR_DRIVE_OUT,
   output logic BSR_DRIVE_EN_OUT,
   output logic PADS_HIGHZ_OUT,
   output logic RESERVED_INSTR_OUT,
   // system side status
   output logic TAP_READY_OUT,
   output logic [4:0] INSTR_OUT
);
   typedef struct packed {
      jtd_pkg::jtd_path_type path;
      logic [2:0] user;
      logic reserved;
   } jtd_decode_type;

   // instruction code to scan path
   function automatic jtd_decode_type decode(input logic [4:0] code);
      jtd_decode_type d;
      d.path = jtd_pkg::PATH_BYPASS;
      d.user = 3'h0;
      d.reserved = 1'b0;
      if (code == jtd_pkg::INSTR_EXTEST || code == jtd_pkg::INSTR_INTEST
          || code == jtd_pkg::INSTR_SAMPLE)
      begin
         d.path = jtd_pkg::PATH_BSR;
      end
      else if (code == jtd_pkg::INSTR_HIGHZ || code == jtd_pkg::INSTR_CLAMP)
      begin
         d.path = jtd_pkg::PATH_BYPASS;
      end
      else if (code == jtd_pkg::INSTR_BYPASS)
      begin
         d.path = jtd_pkg::PATH_BYPASS;
      end
      else if (code == jtd_pkg::IDENTIFY_INSTR)
      begin
         d.path = jtd_pkg::PATH_IDENT;
      end
      else if (code == jtd_pkg::BIAS_PROGRAM_INSTR)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_BIAS);
      end
      else if (code == jtd_pkg::LINE_PATTERN_FIRST_INSTR)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_LINE_FIRST);
      end
      else if (code == jtd_pkg::LINE_PATTERN_SECOND_INSTR)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_LINE_SECOND);
      end
      else if (code == jtd_pkg::DISCRIMINATOR_MASK_INSTR)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_DISC);
      end
      else if (code == jtd_pkg::SEQUENCER_INSTR)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_SEQ);
      end
      else if (code == jtd_pkg::CONTROL_INSTR)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_CTRL);
      end
      else if (code == jtd_pkg::READOUT_CONFIG_SECOND)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_RO_SECOND);
      end
      else if (code == jtd_pkg::READOUT_CONFIG_FIRST)
      begin
         d.path = jtd_pkg::PATH_USER;
         d.user = 3'(jtd_pkg::U_RO_FIRST);
      end
      else if (code >= jtd_pkg::RESERVED_CODE_A && code <= jtd_pkg::RESERVED_CODE_H)
      begin
         d.reserved = 1'b1;
      end
      return d;
   endfunction

   jtd_tap_if tap ();

   // system domain: power-on counter and instruction mirror
   logic [jtd_pkg::POR_CNT_WIDTH-1:0] por_cnt;
   logic [jtd_pkg::POR_CNT_WIDTH-1:0] next_por_cnt;
   logic por_done;
   logic next_por_done;
   logic tog_meta;
   logic tog_sync;
   logic tog_prev;
   logic [4:0] instr_mirror;
   logic [4:0] next_instr_mirror;

   // link domain state
   logic por_meta;
   logic por_sync;
   logic [BSR_WIDTH-1:0] pad_meta;
   logic [BSR_WIDTH-1:0] pad_sync;
   logic [4:0] ir_shift;
   logic [4:0] next_ir_shift;
   logic [4:0] ir_reg;
   logic [4:0] next_ir_reg;
   logic ir_tog;
   logic next_ir_tog;
   logic bypass_bit;
   logic next_bypass_bit;
   logic [31:0] id_shift;
   logic [31:0] next_id_shift;
   logic [BSR_WIDTH-1:0] bsr_shift;
   logic [BSR_WIDTH-1:0] next_bsr_shift;
   logic [BSR_WIDTH-1:0] bsr_hold;
   logic [BSR_WIDTH-1:0] next_bsr_hold;
   logic [USER_COUNT-1:0] next_sel;
   logic [USER_COUNT-1:0] next_cap;
   logic [USER_COUNT-1:0] next_shf;
   logic [USER_COUNT-1:0] next_upd;
   logic next_drive_en;
   logic next_highz;
   logic next_reserved;
   logic serial_out;
   logic next_oe;
   jtd_decode_type cur_dec;
   jtd_decode_type new_dec;

   // power-on hold counted on the system clock
   always_comb
   begin
      next_por_cnt = por_cnt;
      next_por_done = por_done;
      if (por_cnt < jtd_pkg::POR_CNT_WIDTH'(jtd_pkg::POR_CYCLES))
      begin
         next_por_cnt = por_cnt + 1'b1;
      end
      else
      begin
         next_por_done = 1'b1;
      end
      next_instr_mirror = instr_mirror;
      if (tog_sync != tog_prev)
      begin
         next_instr_mirror = ir_reg; // stable long before the toggle lands
      end
   end

   // system domain registers
   always_ff @(posedge CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         por_cnt <= '0;
         por_done <= 1'b0;
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
         tog_prev <= 1'b0;
         instr_mirror <= jtd_pkg::IR_RESET_VALUE;
      end
      else
      begin
         por_cnt <= next_por_cnt;
         por_done <= next_por_done;
         tog_meta <= ir_tog;
         tog_sync <= tog_meta;
         tog_prev <= tog_sync;
         instr_mirror <= next_instr_mirror;
      end
   end

   assign TAP_READY_OUT = por_done;
   assign INSTR_OUT = instr_mirror;

   // port controller, held in reset until power-on completes
   jtd_tap_fsm u_fsm
   (
      .tck(TCK_IN),
      .rst_n(NRST_IN),
      .hold(!por_sync),
      .tms(TMS_IN),
      .tap(tap.fsm)
   );

   // instruction and built-in data registers
   always_comb
   begin
      next_ir_shift = ir_shift;
      next_ir_reg = ir_reg;
      next_bypass_bit = bypass_bit;
      next_id_shift = id_shift;
      next_bsr_shift = bsr_shift;
      next_bsr_hold = bsr_hold;
      cur_dec = decode(ir_reg);
      case (tap.state)
         jtd_pkg::TAP_RESET: next_ir_reg = jtd_pkg::IR_RESET_VALUE;
         jtd_pkg::TAP_CAP_IR: next_ir_shift = {ir_reg[4:jtd_pkg::IR_MARK_WIDTH],
                                                jtd_pkg::IR_CAPTURE_MARK};
         jtd_pkg::TAP_SHIFT_IR: next_ir_shift = {TDI_IN, ir_shift[4:1]};
         jtd_pkg::TAP_UPD_IR: next_ir_reg = ir_shift;
         jtd_pkg::TAP_CAP_DR:
         begin
            next_bypass_bit = 1'b0;
            next_id_shift = ID_VALUE;
            next_bsr_shift = pad_sync;
         end
         jtd_pkg::TAP_SHIFT_DR:
         begin
            if (cur_dec.path == jtd_pkg::PATH_BYPASS)
            begin
               next_bypass_bit = TDI_IN;
            end
            else if (cur_dec.path == jtd_pkg::PATH_IDENT)
            begin
               next_id_shift = {TDI_IN, id_shift[31:1]};
            end
            else if (cur_dec.path == jtd_pkg::PATH_BSR)
            begin
               next_bsr_shift = {TDI_IN, bsr_shift[BSR_WIDTH-1:1]};
            end
         end
         jtd_pkg::TAP_UPD_DR:
         begin
            if (cur_dec.path == jtd_pkg::PATH_BSR)
            begin
               next_bsr_hold = bsr_shift;
            end
         end
         default: next_ir_shift = ir_shift;
      endcase
      if (!por_sync)
      begin
         next_ir_reg = jtd_pkg::IR_RESET_VALUE;
      end
      next_ir_tog = (next_ir_reg != ir_reg) ? !ir_tog : ir_tog;
   end

   // per-register strobes and pad modes from the coming instruction
   always_comb
   begin
      new_dec = decode(next_ir_reg);
      next_drive_en = next_ir_reg == jtd_pkg::INSTR_EXTEST
                      || next_ir_reg == jtd_pkg::INSTR_INTEST
                      || next_ir_reg == jtd_pkg::INSTR_CLAMP;
      next_highz = next_ir_reg == jtd_pkg::INSTR_HIGHZ;
      next_reserved = new_dec.reserved;
   end

   generate
      for (genvar i = 0; i < USER_COUNT; i++)
      begin : g_user
         // select only while this register's instruction is current
         assign next_sel[i] = new_dec.path == jtd_pkg::PATH_USER
                              && new_dec.user == 3'(i);
         assign next_cap[i] = next_sel[i] && tap.next_state == jtd_pkg::TAP_CAP_DR;
         assign next_shf[i] = next_sel[i] && tap.next_state == jtd_pkg::TAP_SHIFT_DR;
         assign next_upd[i] = next_sel[i] && tap.next_state == jtd_pkg::TAP_UPD_DR;
      end
   endgenerate

   // link domain registers on the rising edge
   always_ff @(posedge TCK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         por_meta <= 1'b0;
         por_sync <= 1'b0;
         pad_meta <= '0;
         pad_sync <= '0;
         ir_shift <= jtd_pkg::IR_RESET_VALUE;
         ir_reg <= jtd_pkg::IR_RESET_VALUE;
         ir_tog <= 1'b0;
         bypass_bit <= 1'b0;
         id_shift <= '0;
         bsr_shift <= '0;
         bsr_hold <= '0;
         USER_SELECT_OUT <= '0;
         USER_CAPTURE_OUT <= '0;
         USER_SHIFT_OUT <= '0;
         USER_UPDATE_OUT <= '0;
         BSR_DRIVE_EN_OUT <= 1'b0;
         PADS_HIGHZ_OUT <= 1'b0;
         RESERVED_INSTR_OUT <= 1'b0;
      end
      else
      begin
         por_meta <= por_done;
         por_sync <= por_meta;
         pad_meta <= BSR_PADS_IN;
         pad_sync <= pad_meta;
         ir_shift <= next_ir_shift;
         ir_reg <= next_ir_reg;
         ir_tog <= next_ir_tog;
         bypass_bit <= next_bypass_bit;
         id_shift <= next_id_shift;
         bsr_shift <= next_bsr_shift;
         bsr_hold <= next_bsr_hold;
         USER_SELECT_OUT <= next_sel;
         USER_CAPTURE_OUT <= next_cap;
         USER_SHIFT_OUT <= next_shf;
         USER_UPDATE_OUT <= next_upd;
         BSR_DRIVE_EN_OUT <= next_drive_en;
         PADS_HIGHZ_OUT <= next_highz;
         RESERVED_INSTR_OUT <= next_reserved;
      end
   end

   assign BSR_DRIVE_OUT = bsr_hold;

   // serial out mux, least significant bit leaves first
   always_comb
   begin
      serial_out = bypass_bit;
      if (tap.state == jtd_pkg::TAP_SHIFT_IR)
      begin
         serial_out = ir_shift[0];
      end
      else if (cur_dec.path == jtd_pkg::PATH_IDENT)
      begin
         serial_out = id_shift[0];
      end
      else if (cur_dec.path == jtd_pkg::PATH_BSR)
      begin
         serial_out = bsr_shift[0];
      end
      else if (cur_dec.path == jtd_pkg::PATH_USER)
      begin
         serial_out = USER_TDO_IN[cur_dec.user];
      end
      next_oe = tap.state == jtd_pkg::TAP_SHIFT_IR || tap.state == jtd_pkg::TAP_SHIFT_DR;
   end

   // serial out changes on the falling edge
   always_ff @(negedge TCK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         TDO_OUT <= 1'b0;
         TDO_OE_OUT <= 1'b0;
      end
      else
      begin
         TDO_OUT <= serial_out;
         TDO_OE_OUT <= next_oe;
      end
   end
endmodule

// >>> bench/jtd_host.sv
// host-side model of the serial test link master
`timescale 1ns/1ps
module jtd_host
(
   // link to the port
   output logic TCK_OUT,
   output logic TMS_OUT,
   output logic TDI_OUT,
   input wire logic TDO_IN,
   input wire logic TDO_OE_IN
);
   logic tdo_last = 1'b0;
   logic tdo_line;
   // a released line shows the inverse of the last driven bit
   always @(TDO_IN or TDO_OE_IN)
   begin
      if (TDO_OE_IN)
         tdo_last = TDO_IN;
   end
   assign tdo_line = TDO_OE_IN ? TDO_IN : ~tdo_last;
   initial
   begin
      TCK_OUT = 1'b0;
      TMS_OUT = 1'b1;
      TDI_OUT = 1'b0;
   end
   // one link cycle; clock stands low between calls
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      TMS_OUT = tms;
      TDI_OUT = tdi;
      #1;
      tdo = tdo_line;
      TCK_OUT = 1'b1;
      #3;
      TCK_OUT = 1'b0;
      #2;
   endtask
   // through test-logic-reset into idle
   task automatic to_idle();
      logic d;
      repeat (5) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask
   // shift n bits, then update and back to idle
   task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
      logic d;
      dout = '0;
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], d);
         dout[i] = d;
      end
      step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask
   // instruction scan from idle
   task automatic ir_scan(input logic [4:0] code, output logic [4:0] cap);
      logic d;
      logic [63:0] o;
      step(1'b1, 1'b0, d);
      step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
      step(1'b0, 1'b0, d);
      shift(5, {59'h0, code}, o);
      cap = o[4:0];
   endtask
   // data scan from idle
   task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
      logic d;
      step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
      step(1'b0, 1'b0, d);
      shift(n, din, dout);
   endtask
endmodule

// >>> bench/jtd_decoder_sva.sv
// port checker of the test access port decoder
`timescale 1ns/1ps
module jtd_decoder_chk
#(
   parameter int USER_COUNT = 8
)
(
   // clocks and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic TCK_IN,
   // watched outputs
   input wire logic TDO_OE_OUT,
   input wire logic [USER_COUNT-1:0] USER_SELECT_OUT,
   input wire logic [USER_COUNT-1:0] USER_CAPTURE_OUT,
   input wire logic [USER_COUNT-1:0] USER_SHIFT_OUT,
   input wire logic [USER_COUNT-1:0] USER_UPDATE_OUT,
   input wire logic BSR_DRIVE_EN_OUT,
   input wire logic PADS_HIGHZ_OUT,
   input wire logic RESERVED_INSTR_OUT,
   input wire logic TAP_READY_OUT,
   input wire logic [4:0] INSTR_OUT
);
   logic [7:0] por_cnt;
   logic [7:0] next_por_cnt;
   // system cycles since reset release
   always_comb
   begin
      next_por_cnt = por_cnt;
      if (por_cnt != 8'hFF)
         next_por_cnt = por_cnt + 8'h01;
   end
   always_ff @(posedge CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         por_cnt <= 8'h00;
      else
         por_cnt <= next_por_cnt;
   end
   chk_select_onehot: assert property (@(posedge TCK_IN) disable iff (!NRST_IN)
      $onehot0(USER_SELECT_OUT)) else $error("more than one user select");
   chk_strobe_gated: assert property (@(posedge TCK_IN) disable iff (!NRST_IN)
      ((USER_CAPTURE_OUT | USER_SHIFT_OUT | USER_UPDATE_OUT) & ~USER_SELECT_OUT) == '0)
      else $error("user strobe without select");
   chk_capture_once: assert property (@(posedge TCK_IN) disable iff (!NRST_IN)
      |USER_CAPTURE_OUT |=> USER_CAPTURE_OUT == '0
      && (USER_SHIFT_OUT & ~$past(USER_CAPTURE_OUT)) == '0) else $error("capture not single");
   chk_update_single: assert property (@(posedge TCK_IN) disable iff (!NRST_IN)
      |USER_UPDATE_OUT |=> USER_UPDATE_OUT == '0 && USER_SHIFT_OUT == '0)
      else $error("update not single");
   chk_shift_drives: assert property (@(posedge TCK_IN) disable iff (!NRST_IN)
      |USER_SHIFT_OUT |-> TDO_OE_OUT) else $error("serial out not driven in shift");
   chk_update_released: assert property (@(posedge TCK_IN) disable iff (!NRST_IN)
      |USER_UPDATE_OUT |-> !TDO_OE_OUT) else $error("serial out driven in update");
   chk_mode_exclusive: assert property (@(posedge TCK_IN) disable iff (!NRST_IN)
      $onehot0({BSR_DRIVE_EN_OUT, PADS_HIGHZ_OUT, RESERVED_INSTR_OUT, |USER_SELECT_OUT}))
      else $error("instruction modes overlap");
   chk_por_hold: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      TAP_READY_OUT |-> por_cnt >= 8'(jtd_pkg::POR_CYCLES - 2)) else $error("ready too early");
   chk_reset_instr: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      !TAP_READY_OUT |-> INSTR_OUT == 5'h0E) else $error("instruction not identify in reset");
endmodule
bind jtd_decoder jtd_decoder_chk #(.USER_COUNT(USER_COUNT)) chk_u (.CLK_IN(CLK_IN),
   .NRST_IN(NRST_IN), .TCK_IN(TCK_IN), .TDO_OE_OUT(TDO_OE_OUT),
   .USER_SELECT_OUT(USER_SELECT_OUT), .USER_CAPTURE_OUT(USER_CAPTURE_OUT),
   .USER_SHIFT_OUT(USER_SHIFT_OUT), .USER_UPDATE_OUT(USER_UPDATE_OUT),
   .BSR_DRIVE_EN_OUT(BSR_DRIVE_EN_OUT), .PADS_HIGHZ_OUT(PADS_HIGHZ_OUT),
   .RESERVED_INSTR_OUT(RESERVED_INSTR_OUT), .TAP_READY_OUT(TAP_READY_OUT),
   .INSTR_OUT(INSTR_OUT));

// >>> bench/tb.sv
// self-checking bench of the test access port decoder
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] ID_VAL = 32'h5EED0C01; // value is arbitrary
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, drive_en, highz, rsvd, ready;
   logic [7:0] user_tdo, user_sel, user_cap, user_shift, user_upd;
   logic [9:0] pads = 10'h2B5;
   logic [9:0] drive;
   logic [4:0] instr;
   logic [7:0] ureg [8];
   logic [31:0] lfsr = 32'h18250;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_upd = 0;
   // system clock
   always #20 clk = ~clk;
   jtd_decoder #(.ID_VALUE(ID_VAL)) dut_u (.CLK_IN(clk), .NRST_IN(nrst), .TCK_IN(tck),
      .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe), .USER_TDO_IN(user_tdo),
      .USER_SELECT_OUT(user_sel), .USER_CAPTURE_OUT(user_cap), .USER_SHIFT_OUT(user_shift),
      .USER_UPDATE_OUT(user_upd), .BSR_PADS_IN(pads), .BSR_DRIVE_OUT(drive),
      .BSR_DRIVE_EN_OUT(drive_en), .PADS_HIGHZ_OUT(highz), .RESERVED_INSTR_OUT(rsvd),
      .TAP_READY_OUT(ready), .INSTR_OUT(instr));
   jtd_host host_u (.TCK_OUT(tck), .TMS_OUT(tms), .TDI_OUT(tdi), .TDO_IN(tdo),
      .TDO_OE_IN(tdo_oe));
   // external user registers, shift in at the top
   always @(posedge tck)
   begin
      for (int i = 0; i < 8; i++)
         if (user_shift[i])
            ureg[i] <= {tdi, ureg[i][7:1]};
      // count capture and update pulses seen
      n_upd = n_upd + ((user_upd != 8'h00) ? 1 : 0) + ((user_cap != 8'h00) ? 1 : 0);
   end
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         user_tdo[i] = ureg[i][0];
   end
   // expected user select per code
   function automatic logic [7:0] sel_of(input logic [4:0] c);
      case (c)
         5'h0F: return 8'h01;
         5'h10: return 8'h02;
         5'h11: return 8'h04;
         5'h12: return 8'h08;
         5'h13: return 8'h10;
         5'h14: return 8'h20;
         5'h1D: return 8'h40;
         5'h1E: return 8'h80;
         default: return 8'h00;
      endcase
   endfunction
   // expected scan path length per code
   function automatic int len_of(input logic [4:0] c);
      if (c == 5'h01 || c == 5'h03 || c == 5'h05)
         return jtd_pkg::BSR_WIDTH;
      if (c == 5'h0E)
         return jtd_pkg::ID_WIDTH;
      return (sel_of(c) != 8'h00) ? 8 : 1;
   endfunction
   // expected drive, high-impedance and reserved flags
   function automatic logic [2:0] mode_of(input logic [4:0] c);
      return {c == 5'h01 || c == 5'h03 || c == 5'h04, c == 5'h02, c >= 5'h15 && c <= 5'h1C};
   endfunction
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // reset with link pulses, wait for ready, walk to idle
   task automatic do_reset();
      logic d;
      @(posedge clk);
      #1 nrst = 1'b0;
      host_u.step(1'b1, 1'b0, d);
      host_u.step(1'b1, 1'b0, d);
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      for (int i = 0; i < 100 && ready !== 1'b1; i++)
         @(posedge clk) #1;
      check("ready", 64'h1, 64'(ready));
      host_u.to_idle();
      check("instr after reset", 64'h0E, 64'(instr));
   endtask
   // watchdog
   initial
   begin
      #200000;
      n_mismatch++;
      stop_test();
   end
   initial
   begin
      logic [4:0] code, cap, prev;
      logic [63:0] din, dout, exp, mask;
      int len;
      foreach (ureg[i])
         ureg[i] = 8'h00;
      do_reset();
      host_u.dr_scan(32, 64'h0, dout);
      check("identity", 64'(ID_VAL), dout);
      prev = 5'h0E;
      for (int c = 0; c < 32; c++)
      begin
         code = 5'(c);
         host_u.ir_scan(code, cap);
         check("ir capture", 64'({prev[4:2], 2'h1}), 64'(cap));
         check("user select", 64'(sel_of(code)), 64'(user_sel));
         check("mode flags", 64'(mode_of(code)), 64'({drive_en, highz, rsvd}));
         repeat (8) @(posedge clk);
         #1 check("instr copy", 64'(code), 64'(instr));
         lfsr = lfsr_next(lfsr);
         din[63:32] = lfsr;
         lfsr = lfsr_next(lfsr);
         din[31:0] = lfsr;
         pads = lfsr[9:0];
         len = len_of(code);
         n_upd = 0;
         host_u.dr_scan(40, din, dout);
         check("user strobes", (sel_of(code) != 8'h00) ? 64'h2 : 64'h0, 64'(n_upd));
         exp = (din << len) & 64'hFF_FFFF_FFFF;
         mask = 64'hFF_FFFF_FFFF;
         if (len == 10)
            exp = exp | 64'(pads);
         if (len == 32)
            exp = exp | 64'(ID_VAL);
         if (len == 8)
            mask = mask & ~64'hFF;
         check("scan path", exp, dout & mask);
         if (len == 10)
            check("boundary update", 64'(din[39:30]), 64'(drive));
         prev = code;
      end
      do_reset();
      stop_test();
   end
endmodule
